// ### hdl/cdrsb_pkg.sv
// constants, types and helpers for the cdr serial channel bank
// assumes one 250 MHz system clock and no software-visible registers
package cdrsb_pkg;

	// ************************************************
	// ratio limits and bank sizes
	// ************************************************
	localparam int W_MIN          = 1;
	localparam int J_MIN          = 3;
	localparam int RATIO_RUN_MAX  = 12;
	localparam int CH_SMALL       = 8;
	localparam int CH_LARGE       = 18;
	localparam int GCLK_SMALL_LO  = 4;
	localparam int GCLK_LARGE_LO  = 9;
	localparam int RATE_FAST_MBPS = 1250;
	localparam int RATE_SLOW_MBPS = 1000;
	localparam int FAST_SLOTS     = 8;

	// ************************************************
	// timing and widths
	// ************************************************
	localparam real SYS_PERIOD_NS = 4.0;
	localparam int  PER_W         = 16;
	localparam logic [3:0] LOCK_EDGES = 4'h8;
	localparam logic [7:0] RUN_LIMIT  = 8'h50;

	// ************************************************
	// types and functions
	// ************************************************
	typedef enum logic [1:0] {
		CDRSB_HUNT   = 2'b00,
		CDRSB_TRACK  = 2'b01,
		CDRSB_LOCKED = 2'b10
	} cdrsb_lock_t;

	// 1..12 above lo, or 14, 16, 18, 20
	function automatic logic ratioOk(input int v, input int lo);
		ratioOk = (v >= lo && v <= RATIO_RUN_MAX) ||
			v == 14 || v == 16 || v == 18 || v == 20;
	endfunction

endpackage

// ### hdl/cdrsb_buf.sv
// two-entry word buffer, head word held in a register
// assumes pushes and pops on the same clock as the caller
`timescale 1ns/1ps
module cdrsb_buf #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 2
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);

	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] ent_ff [DEPTH];
	logic [WIDTH-1:0] nxt_ent [DEPTH];
	logic [CW-1:0]    cnt_ff;
	logic [CW-1:0]    nxt_cnt;
	logic             push;
	logic             pop;
	logic [CW-1:0]    slot;

	// ************************************************
	// shift-down queue, entry 0 is the head
	// ************************************************
	always_comb begin
		pop     = outValid && outReady;
		push    = inValid && inReady;
		slot    = pop ? cnt_ff - CW'(1) : cnt_ff;
		nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
		for (int i = 0; i < DEPTH; i++) begin
			nxt_ent[i] = ent_ff[i];
			if (pop && i < DEPTH - 1) begin
				nxt_ent[i] = ent_ff[i + 1];
			end
			if (push && CW'(i) == slot) begin
				nxt_ent[i] = inData;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_ff <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				ent_ff[i] <= '0;
			end
		end else begin
			cnt_ff <= nxt_cnt;
			ent_ff <= nxt_ent;
		end
	end

	// full refuses the writer: stored words wait for a stalled reader, the channel drops the refused word
	assign inReady  = cnt_ff != CW'(DEPTH);
	assign outValid = cnt_ff != '0;
	assign outData  = ent_ff[0];

endmodule // cdrsb_buf

// ### hdl/cdrsb_channel.sv
// one receive and one transmit lane of the cdr serial channel bank
// assumes serial and reference pins are asynchronous to sys_clk
`timescale 1ns/1ps
module cdrsb_channel #(
	parameter int MULT_W    = 10,
	parameter int DES_J     = 10,
	parameter int NUM_CH    = 8,
	parameter int CH_NUM    = 4,
	parameter int RATE_MBPS = 1000,
	parameter bit FAST_SLOT = 1'b0
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             serialRefclkInA,
	input  wire logic             serialRefclkInB,
	input  wire logic             rxRefSel,
	input  wire logic             txRefSel,
	input  wire logic             rxSerial,
	input  wire logic             rxBypass,
	output logic      [DES_J-1:0] rxData,
	output logic                  rxValid,
	input  wire logic             rxReady,
	output logic                  rxLocked,
	output logic                  rxWordClkEn,
	output logic                  rxGlobalClkEn,
	input  wire logic [DES_J-1:0] txData,
	input  wire logic             txValid,
	output logic                  txReady,
	output logic                  txSerial,
	output logic                  cfgError
);

	localparam int PW = cdrsb_pkg::PER_W;
	localparam int CJ = $clog2(DES_J);
	localparam logic [PW:0] W_INC = (PW + 1)'(MULT_W);
	localparam logic [CJ-1:0] J_LAST = CJ'(DES_J - 1);
	localparam bit GCLK_OK =
		(NUM_CH == cdrsb_pkg::CH_SMALL &&
		(CH_NUM == cdrsb_pkg::GCLK_SMALL_LO ||
		CH_NUM == cdrsb_pkg::GCLK_SMALL_LO + 1)) ||
		(NUM_CH == cdrsb_pkg::CH_LARGE &&
		(CH_NUM == cdrsb_pkg::GCLK_LARGE_LO ||
		CH_NUM == cdrsb_pkg::GCLK_LARGE_LO + 1));
	localparam bit CFG_BAD =
		!cdrsb_pkg::ratioOk(MULT_W, cdrsb_pkg::W_MIN) ||
		!cdrsb_pkg::ratioOk(DES_J, cdrsb_pkg::J_MIN) ||
		!(NUM_CH == cdrsb_pkg::CH_SMALL ||
		NUM_CH == cdrsb_pkg::CH_LARGE) ||
		CH_NUM < 1 || CH_NUM > NUM_CH ||
		RATE_MBPS > cdrsb_pkg::RATE_FAST_MBPS ||
		(RATE_MBPS > cdrsb_pkg::RATE_SLOW_MBPS && !FAST_SLOT);

	// ************************************************
	// pin synchronisers, change taken when 2nd and 3rd agree
	// ************************************************
	logic [2:0] pinIn;
	logic [2:0] s1_ff;
	logic [2:0] s2_ff;
	logic [2:0] s3_ff;
	logic [2:0] stab_ff;
	logic [2:0] nxt_stab;
	logic [2:0] rise;

	assign pinIn = {rxSerial, serialRefclkInB, serialRefclkInA};

	always_comb begin
		nxt_stab = stab_ff;
		for (int i = 0; i < 3; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_stab[i] = s3_ff[i];
			end
		end
		rise = nxt_stab & ~stab_ff;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s1_ff   <= 3'h0;
			s2_ff   <= 3'h0;
			s3_ff   <= 3'h0;
			stab_ff <= 3'h0;
		end else begin
			s1_ff   <= pinIn;
			s2_ff   <= s1_ff;
			s3_ff   <= s2_ff;
			stab_ff <= nxt_stab;
		end
	end

	// ************************************************
	// reference period meters, read by the multipliers and the lock tracking
	// ************************************************
	logic [PW-1:0] rcnt_ff [2];
	logic [PW-1:0] per_ff  [2];
	logic [PW-1:0] nxt_rcnt [2];
	logic [PW-1:0] nxt_per  [2];

	always_comb begin
		for (int k = 0; k < 2; k++) begin
			nxt_rcnt[k] = rcnt_ff[k] + PW'(1);
			nxt_per[k]  = per_ff[k];
			if (rise[k]) begin
				nxt_rcnt[k] = PW'(1);
				nxt_per[k]  = rcnt_ff[k];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rcnt_ff <= '{default: '0};
			per_ff  <= '{default: '0};
		end else begin
			rcnt_ff <= nxt_rcnt;
			per_ff  <= nxt_per;
		end
	end

	// ************************************************
	// multipliers: W ticks per reference period
	// ************************************************
	logic [PW:0]   rxAcc_ff;
	logic [PW:0]   txAcc_ff;
	logic [PW:0]   nxt_rxAcc;
	logic [PW:0]   nxt_txAcc;
	logic [PW:0]   rxPer;
	logic [PW:0]   txPer;
	logic          rxTick;
	logic          txTick;
	logic          dataEdge;

	// one ref per rate group keeps at most two rates per direction
	assign rxPer = {1'b0, rxRefSel ? per_ff[1] : per_ff[0]};
	assign txPer = {1'b0, txRefSel ? per_ff[1] : per_ff[0]};
	// nrz: every level change is a bit boundary
	assign dataEdge = stab_ff[2] != nxt_stab[2];

	always_comb begin
		rxTick    = 1'b0;
		txTick    = 1'b0;
		nxt_rxAcc = rxAcc_ff + W_INC;
		nxt_txAcc = txAcc_ff + W_INC;
		if (rxPer != '0 && nxt_rxAcc >= rxPer) begin
			rxTick    = 1'b1;
			nxt_rxAcc = nxt_rxAcc - rxPer;
		end
		if (txPer != '0 && nxt_txAcc >= txPer) begin
			txTick    = 1'b1;
			nxt_txAcc = nxt_txAcc - txPer;
		end
		if (dataEdge) begin
			// restart phase so the next tick lands mid-bit
			nxt_rxAcc = rxPer >> 1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rxAcc_ff <= '0;
			txAcc_ff <= '0;
		end else begin
			rxAcc_ff <= nxt_rxAcc;
			txAcc_ff <= nxt_txAcc;
		end
	end

	// ************************************************
	// lock tracking of the recovery unit
	// ************************************************
	cdrsb_pkg::cdrsb_lock_t lock_ff;
	cdrsb_pkg::cdrsb_lock_t nxt_lock;
	logic [3:0] edges_ff;
	logic [3:0] nxt_edges;
	logic [7:0] run_ff;
	logic [7:0] nxt_run;

	always_comb begin
		nxt_lock  = lock_ff;
		nxt_edges = edges_ff;
		nxt_run   = dataEdge ? 8'h00 : run_ff + 8'(rxTick);
		case (lock_ff)
			cdrsb_pkg::CDRSB_HUNT: begin
				nxt_edges = 4'h0;
				if (rxPer != '0) begin
					nxt_lock = cdrsb_pkg::CDRSB_TRACK;
				end
			end
			cdrsb_pkg::CDRSB_TRACK: begin
				nxt_edges = edges_ff + 4'(dataEdge);
				if (nxt_edges == cdrsb_pkg::LOCK_EDGES) begin
					nxt_lock = cdrsb_pkg::CDRSB_LOCKED;
				end
			end
			cdrsb_pkg::CDRSB_LOCKED: ;
			default: nxt_lock = cdrsb_pkg::CDRSB_HUNT;
		endcase
		// too long without a transition: phase is no longer trusted
		if (run_ff > cdrsb_pkg::RUN_LIMIT) begin
			nxt_lock = cdrsb_pkg::CDRSB_HUNT;
			nxt_run  = 8'h00;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lock_ff  <= cdrsb_pkg::CDRSB_HUNT;
			edges_ff <= 4'h0;
			run_ff   <= 8'h00;
		end else begin
			lock_ff  <= nxt_lock;
			edges_ff <= nxt_edges;
			run_ff   <= nxt_run;
		end
	end

	// ************************************************
	// deserialiser, word strobe and buffered output
	// ************************************************
	logic             locked;
	logic [DES_J-1:0] rxShift_ff;
	logic [DES_J-1:0] nxt_rxShift;
	logic [CJ-1:0]    rxCnt_ff;
	logic [CJ-1:0]    nxt_rxCnt;
	logic             wordStb;
	logic [DES_J-1:0] bufData;
	logic             bufValid;
	logic             bufReady;
	logic             bufPop;
	logic             outFree;
	logic [DES_J-1:0] rxData_ff;
	logic             rxValid_ff;
	logic             wclk_ff;
	logic             gclk_ff;
	logic [DES_J-1:0] nxt_rxData;
	logic             nxt_rxValid;

	assign locked = lock_ff == cdrsb_pkg::CDRSB_LOCKED;
	assign outFree = !rxValid_ff || rxReady;

	always_comb begin
		nxt_rxShift = rxShift_ff;
		nxt_rxCnt   = rxCnt_ff;
		wordStb     = 1'b0;
		if (rxTick) begin
			nxt_rxShift = {stab_ff[2], rxShift_ff[DES_J-1:1]};
			nxt_rxCnt   = (rxCnt_ff == J_LAST) ? '0 : rxCnt_ff + CJ'(1);
			wordStb     = rxCnt_ff == J_LAST;
		end
		bufPop      = !rxBypass && outFree;
		nxt_rxData  = rxData_ff;
		nxt_rxValid = rxValid_ff && !rxReady;
		if (rxBypass && wordStb && locked && outFree) begin
			nxt_rxData  = nxt_rxShift;
			nxt_rxValid = 1'b1;
		end else if (bufPop && bufValid) begin
			nxt_rxData  = bufData;
			nxt_rxValid = 1'b1;
		end
		if (!locked) begin
			nxt_rxValid = 1'b0;
		end
	end

	cdrsb_buf #(
		.WIDTH (DES_J),
		.DEPTH (2)
	) u_rxBuf (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.inData   (nxt_rxShift),
		.inValid  (wordStb && locked && !rxBypass),
		.inReady  (bufReady),
		.outData  (bufData),
		.outValid (bufValid),
		.outReady (bufPop)
	);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rxShift_ff <= '0;
			rxCnt_ff   <= '0;
			rxData_ff  <= '0;
			rxValid_ff <= 1'b0;
			wclk_ff    <= 1'b0;
			gclk_ff    <= 1'b0;
		end else begin
			rxShift_ff <= nxt_rxShift;
			rxCnt_ff   <= nxt_rxCnt;
			rxData_ff  <= nxt_rxData;
			rxValid_ff <= nxt_rxValid;
			wclk_ff    <= wordStb;
			gclk_ff    <= wordStb && GCLK_OK;
		end
	end

	// ************************************************
	// transmitter: holding word, serialiser on txTick
	// ************************************************
	logic [DES_J-1:0] hold_ff;
	logic             holdV_ff;
	logic [DES_J-1:0] txShift_ff;
	logic [CJ-1:0]    txCnt_ff;
	logic             txOut_ff;
	logic [DES_J-1:0] nxt_hold;
	logic             nxt_holdV;
	logic [DES_J-1:0] nxt_txShift;
	logic [CJ-1:0]    nxt_txCnt;
	logic             nxt_txOut;
	logic             txLoad;

	always_comb begin
		nxt_hold    = hold_ff;
		nxt_holdV   = holdV_ff;
		nxt_txShift = txShift_ff;
		nxt_txCnt   = txCnt_ff;
		nxt_txOut   = txOut_ff;
		txLoad      = txTick && txCnt_ff == '0;
		if (txTick) begin
			nxt_txOut   = txLoad ? hold_ff[0] : txShift_ff[0];
			nxt_txShift = txLoad ? hold_ff >> 1 : txShift_ff >> 1;
			nxt_txCnt   = (txCnt_ff == J_LAST) ? '0 : txCnt_ff + CJ'(1);
			if (txLoad) begin
				nxt_holdV = 1'b0;
			end
		end
		// an empty holding word resends its last value, never zeros mid-word
		if (txValid && !holdV_ff) begin
			nxt_hold  = txData;
			nxt_holdV = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hold_ff    <= '0;
			holdV_ff   <= 1'b0;
			txShift_ff <= '0;
			txCnt_ff   <= '0;
			txOut_ff   <= 1'b0;
		end else begin
			hold_ff    <= nxt_hold;
			holdV_ff   <= nxt_holdV;
			txShift_ff <= nxt_txShift;
			txCnt_ff   <= nxt_txCnt;
			txOut_ff   <= nxt_txOut;
		end
	end

	logic cfg_ff;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg_ff <= 1'b0;
		end else begin
			cfg_ff <= CFG_BAD;
		end
	end

	assign rxData        = rxData_ff;
	assign rxValid       = rxValid_ff;
	assign rxLocked      = lock_ff == cdrsb_pkg::CDRSB_LOCKED;
	assign rxWordClkEn   = wclk_ff;
	assign rxGlobalClkEn = gclk_ff;
	assign txReady       = !holdV_ff;
	assign txSerial      = txOut_ff;
	assign cfgError      = cfg_ff;

	// ************************************************
	// assertions
	// ************************************************
	property p_lockGate;
		@(posedge sys_clk) disable iff (rst)
		!locked |=> !rxValid;
	endproperty
	a_lockGate: assert property (p_lockGate)
		else $error("output valid without lock");

	property p_wordClk;
		@(posedge sys_clk) disable iff (rst)
		rxTick && rxCnt_ff == J_LAST |=> rxWordClkEn;
	endproperty
	a_wordClk: assert property (p_wordClk)
		else $error("word clock enable missing");

	property p_gclk;
		@(posedge sys_clk) disable iff (rst)
		rxWordClkEn |-> rxGlobalClkEn == GCLK_OK;
	endproperty
	a_gclk: assert property (p_gclk)
		else $error("global clock drive on wrong channel");

	property p_cfg;
		@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> cfgError == CFG_BAD;
	endproperty
	a_cfg: assert property (p_cfg)
		else $error("configuration check wrong");

	property p_txShift;
		@(posedge sys_clk) disable iff (rst)
		txTick && txCnt_ff != '0 |=> txSerial == $past(txShift_ff[0]);
	endproperty
	a_txShift: assert property (p_txShift)
		else $error("serial bit not from shifter");

	property p_txTake;
		@(posedge sys_clk) disable iff (rst)
		txValid && txReady && !txLoad |=> !txReady [*1] ##0
			hold_ff == $past(txData);
	endproperty
	a_txTake: assert property (p_txTake)
		else $error("transmit word not taken");

	property p_phase;
		@(posedge sys_clk) disable iff (rst)
		dataEdge |=> rxAcc_ff == ($past(rxPer) >> 1);
	endproperty
	a_phase: assert property (p_phase)
		else $error("phase not realigned on edge");

	property p_bypass;
		@(posedge sys_clk) disable iff (rst)
		rxBypass && wordStb && locked && outFree |=>
			rxValid && rxData == $past(nxt_rxShift);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass word not presented");

	property p_runLoss;
		@(posedge sys_clk) disable iff (rst)
		run_ff > cdrsb_pkg::RUN_LIMIT |=> !rxLocked ##1 !rxValid;
	endproperty
	a_runLoss: assert property (p_runLoss)
		else $error("lock kept through long run");

	c_lock:   cover property (@(posedge sys_clk) disable iff (rst)
		$rose(rxLocked));
	c_word:   cover property (@(posedge sys_clk) disable iff (rst)
		rxValid && rxReady && !rxBypass);
	c_stall:  cover property (@(posedge sys_clk) disable iff (rst)
		!bufReady && rxValid && !rxReady);
	c_txWord: cover property (@(posedge sys_clk) disable iff (rst)
		txValid && txReady);

endmodule // cdrsb_channel

// ### bench/cdrsb_remote.sv
// far end of one lane: nrz bit source and single word catcher
// assumes the bench gives the bit period in sys_clk cycles
`timescale 1ns/1ps
module cdrsb_remote (
	input  wire logic       sys_clk,
	input  wire logic       sendOn,
	input  wire logic [7:0] bitCyc,
	input  wire logic [7:0] pattern,
	input  wire logic       lineIn,
	input  wire logic       arm,
	output logic            lineOut,
	output logic      [7:0] gotWord,
	output logic            gotDone
);
	int cnt;
	int idx;

	// ************************************************
	// source and catcher
	// ************************************************
	initial begin
		lineOut = 1'h0;
		gotWord = 8'h00;
		gotDone = 1'h0;
		cnt = 0;
		idx = 0;
	end

	// line held at last level when idle, so no edges reach the lane
	always @(negedge sys_clk) begin
		if (sendOn) begin
			cnt <= (cnt + 1) % bitCyc;
			if (cnt == 0) begin
				lineOut <= pattern[idx];
				idx <= (idx + 1) % 8;
			end
		end
	end

	// first word must start with a one, the idle line is low
	always begin
		@(posedge arm);
		@(posedge lineIn);
		repeat (bitCyc / 2) @(negedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			gotWord[i] = lineIn;
			repeat (bitCyc) @(negedge sys_clk);
		end
		gotDone = 1'h1;
		@(negedge arm);
		gotDone = 1'h0;
	end
endmodule // cdrsb_remote

// ### bench/cdr_serdes_channel_bank_test.sv
// scenario bench for one channel of the serial bank, plus an off-center side lane for the global gate and config check
// assumes reference pins are free running and off the sys_clk edges
`timescale 1ns/1ps
module cdr_serdes_channel_bank_test;
	localparam logic [7:0] PAT = 8'h4D;
	logic       sys_clk, rst, refA, refB, rxRefSel, txRefSel, rxSerial;
	logic       rxBypass, rxValid, rxReady, rxLocked, wordEn, globEn;
	logic       txValid, txReady, txSerial, cfgError, sendOn, arm, done;
	logic       wordEn2, globEn2, cfg2;
	logic [7:0] rxData, txData, bitCyc, got, rot, pat;
	int         errors, nCompared;

	// ************************************************
	// instances
	// ************************************************
	cdrsb_channel #(.MULT_W(4), .DES_J(8)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .serialRefclkInA(refA),
		.serialRefclkInB(refB), .rxRefSel(rxRefSel), .txRefSel(txRefSel),
		.rxSerial(rxSerial), .rxBypass(rxBypass), .rxData(rxData),
		.rxValid(rxValid), .rxReady(rxReady), .rxLocked(rxLocked),
		.rxWordClkEn(wordEn), .rxGlobalClkEn(globEn), .txData(txData),
		.txValid(txValid), .txReady(txReady), .txSerial(txSerial),
		.cfgError(cfgError));
	// off-center lane with an illegal ratio: global gate and config check
	cdrsb_channel #(.MULT_W(13), .DES_J(8), .CH_NUM(1)) i_side (
		.sys_clk(sys_clk), .rst(rst), .serialRefclkInA(refA),
		.serialRefclkInB(refB), .rxRefSel(rxRefSel), .txRefSel(txRefSel),
		.rxSerial(rxSerial), .rxBypass(rxBypass), .rxData(),
		.rxValid(), .rxReady(rxReady), .rxLocked(),
		.rxWordClkEn(wordEn2), .rxGlobalClkEn(globEn2), .txData(txData),
		.txValid(txValid), .txReady(), .txSerial(), .cfgError(cfg2));
	cdrsb_remote i_remote (.sys_clk(sys_clk), .sendOn(sendOn),
		.bitCyc(bitCyc), .pattern(pat), .lineIn(txSerial), .arm(arm),
		.lineOut(rxSerial), .gotWord(got), .gotDone(done));

	always #2 sys_clk = ~sys_clk;
	// odd offsets keep reference edges clear of sys_clk edges
	initial begin #1; forever #64 refA = ~refA; end
	initial begin #3; forever #96 refB = ~refB; end

	// ************************************************
	// tasks
	// ************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic endSim();
		$display("compared %0d errors %0d", nCompared, errors);
		if (errors == 0 && nCompared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	function automatic logic isRot(input logic [7:0] v);
		logic [15:0] d;
		d = {PAT, PAT};
		isRot = 1'h0;
		for (int i = 0; i < 8; i++) if (d[i +: 8] === v) isRot = 1'h1;
	endfunction

	task automatic t_words(input int want);
		int n;
		int k;
		n = 0;
		k = 0;
		while (k < want && n < 3000) begin
			@(negedge sys_clk);
			n++;
			if (rxValid === 1'h1) begin
				check(rxData, rot);
				k++;
			end
		end
		check(16'(k), 16'(want));
	endtask

	task automatic t_rx(input logic sel, input int cyc);
		int n;
		int gap;
		int side;
		int k;
		rxRefSel = sel;
		bitCyc = 8'(cyc);
		sendOn = 1'h1;
		n = 0;
		while (rxLocked !== 1'h1 && n < 4000) begin
			check(rxValid, 1'h0);
			@(negedge sys_clk);
			n++;
		end
		check(rxLocked, 1'h1);
		gap = -1;
		side = 0;
		k = 0;
		n = 0;
		while (k < 8 && n < 3000) begin
			@(negedge sys_clk);
			n++;
			check(globEn, wordEn);
			check(globEn2, 1'h0);
			if (wordEn2 === 1'h1) side++;
			if (gap >= 0) gap++;
			if (wordEn === 1'h1) begin
				if (gap > 0) check(gap >= 8 * cyc - 2 && gap <= 8 * cyc + 2, 1'h1);
				gap = 0;
			end
			if (rxValid === 1'h1 && k == 0) begin
				rot = rxData;
				check(isRot(rxData), 1'h1);
			end else if (rxValid === 1'h1) check(rxData, rot);
			if (rxValid === 1'h1) k++;
		end
		check(16'(k), 16'h0008);
		check(side > 0, 1'h1);
	endtask

	task automatic t_stall();
		logic [7:0] held;
		rxReady = 1'h0;
		repeat (80) @(negedge sys_clk);
		held = rxData;
		// two words stack behind the held one, later ones are lost
		repeat (300) begin
			@(negedge sys_clk);
			check(rxValid, 1'h1);
			check(rxData, held);
		end
		rxReady = 1'h1;
		t_words(4);
	endtask

	task automatic t_loss();
		int n;
		sendOn = 1'h0;
		n = 0;
		while (rxLocked === 1'h1 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		check(n >= 75 * bitCyc, 1'h1);
		check(rxLocked, 1'h0);
		repeat (2) @(negedge sys_clk);
		check(rxValid, 1'h0);
	endtask

	task automatic t_tx(input logic sel, input int cyc, input logic [7:0] w);
		int n;
		txRefSel = sel;
		bitCyc = 8'(cyc);
		repeat (200) @(negedge sys_clk);
		n = 0;
		while (txReady !== 1'h1 && n < 500) begin
			@(negedge sys_clk);
			n++;
		end
		// the lane resends its last word, so a zero word quiets the line
		txData = 8'h00;
		txValid = 1'h1;
		@(negedge sys_clk);
		txValid = 1'h0;
		n = 0;
		while (txReady !== 1'h1 && n < 500) begin
			@(negedge sys_clk);
			n++;
		end
		check(txReady, 1'h1);
		arm = 1'h1;
		txData = w;
		txValid = 1'h1;
		@(negedge sys_clk);
		txValid = 1'h0;
		check(txReady, 1'h0);
		n = 0;
		while (done !== 1'h1 && n < 2000) begin
			@(negedge sys_clk);
			n++;
		end
		check(done, 1'h1);
		check(got, w);
		arm = 1'h0;
	endtask

	// ************************************************
	// sequence and watchdog
	// ************************************************
	initial begin
		{sys_clk, refA, refB, rxRefSel, txRefSel, rxBypass} = 6'h00;
		{txValid, sendOn, arm} = 3'h0;
		{rst, rxReady} = 2'h3;
		txData = 8'h00;
		bitCyc = 8'h08;
		rot = 8'h00;
		pat = PAT;
		errors = 0;
		nCompared = 0;
		repeat (3) @(negedge sys_clk);
		check(rxValid, 1'h0);
		check(txReady, 1'h1);
		rst = 1'h0;
		repeat (2) @(negedge sys_clk);
		check({cfgError, cfg2}, 2'h1);
		t_tx(1'h0, 8, 8'hB5);
		t_rx(1'h0, 8);
		t_stall();
		rxBypass = 1'h1;
		t_words(4);
		rxBypass = 1'h0;
		t_loss();
		t_rx(1'h1, 12);
		t_tx(1'h1, 12, 8'h9D);
		endSim();
	end

	initial begin
		#200000;
		errors++;
		endSim();
	end
endmodule // cdr_serdes_channel_bank_test
